// >>> usb_int_pkg.sv
package usb_int_pkg;
   // ==========================================
   // register map (byte addresses, one word each)
   localparam logic [11:0] STATUS_ENABLE_ADDR = 12'h000;
   localparam logic [11:0] STATUS_FLAGS_ADDR  = 12'h004;
   localparam logic [11:0] ERROR_FLAGS_ADDR   = 12'h008;
   localparam logic [11:0] ERROR_ENABLE_ADDR  = 12'h00C;

   // ==========================================
   // implemented bit masks
   localparam logic [7:0] STATUS_MASK = 8'h7F;
   localparam logic [7:0] ERROR_MASK  = 8'h9F;

   // ==========================================
   // reset values
   localparam logic [7:0] STATUS_ENABLE_RESET = 8'h00;
   localparam logic [7:0] STATUS_FLAGS_RESET  = 8'h00;
   localparam logic [7:0] ERROR_FLAGS_RESET   = 8'h00;
   localparam logic [7:0] ERROR_ENABLE_RESET  = 8'h00;

   // ==========================================
   // field positions
   localparam int ERROR_SUMMARY_BIT = 1;
   localparam int TURNAROUND_BIT    = 4;
   localparam int DATA_SIZE_BIT     = 3;
   localparam int DATA_CRC_BIT      = 2;
   localparam int TOKEN_CRC_BIT     = 1;
   localparam int PID_CHECK_BIT     = 0;
   localparam int BIT_STUFF_BIT     = 7;

   // ==========================================
   // timing: idle bit times before turnaround timeout
   localparam logic [4:0] TURNAROUND_BIT_TIMES = 5'h10;
endpackage

// >>> usb_int_enable_error_status.sv
`timescale 1ns/100ps
// Functional notes
// (RULE1) status-enable register: bits 6..0 enable sources
// (RULE2) zero enable blocks source, one passes it
// (RULE3) enable bit 1 gates error summary
// (RULE4) error summary is OR of error flags
// (RULE5) each error flag has its own enable
// (RULE6) error flags set in detection cycle
// (RULE7) error flags stay until software writes zero
// (RULE8) turnaround timeout after over 16 idle bits
// (RULE9) data field not whole bytes sets bit3
// (RULE10) data CRC16 failure sets bit2
// (RULE11) token CRC5 failure rejects token, sets bit1
// (RULE12) packet id check failure sets bit0
// (RULE13) bit stuffing violation sets bit7
// (RULE14) unimplemented bits read as zero
// (RULE15) flags set regardless of enables
// (RULE16) only enabled errors drive summary, not writable
// (RULE17) error-enable layout matches error flags
// (RULE18) all enabled status flags form module interrupt
// (RULE19) writing one never sets an error flag
// (RULE20) everything clears at reset
module usb_int_enable_error_status
(
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic [6:0]  statusEvent,
   input  wire logic        bitTimeTick,
   input  wire logic        eopSeen,
   input  wire logic        responseSeen,
   input  wire logic        dataFieldPartial,
   input  wire logic        dataCrcFail,
   input  wire logic        tokenCrcFail,
   input  wire logic        tokenValidIn,
   input  wire logic        pidCheckFail,
   input  wire logic        bitStuffError,
   output logic             tokenAccepted,
   output logic             moduleInterruptFlag,
   output logic             errorSummaryFlag
);
   import usb_int_pkg::*;

   // ==========================================
   // turnaround watch states
   // armed from an end of packet until answered or timed out
   typedef enum logic [0:0]
   {
      WATCH_IDLE  = 1'b0,
      WATCH_ARMED = 1'b1
   } watch_state_t;

   // ==========================================
   // register state
   logic [7:0]   statusEnable_reg;
   logic [7:0]   statusEnable_next;
   logic [7:0]   statusFlags_reg;
   logic [7:0]   statusFlags_next;
   logic [7:0]   errorFlags_reg;
   logic [7:0]   errorFlags_next;
   logic [7:0]   errorEnable_reg;
   logic [7:0]   errorEnable_next;
   logic [4:0]   idleCount_reg;
   logic [4:0]   idleCount_next;
   watch_state_t watch_reg;
   watch_state_t watch_next;

   // ==========================================
   // bus decode
   function automatic logic addrHit
   (
      input logic [11:0] addr,
      input logic [11:0] base
   );
      return addr == base;
   endfunction

   wire        setupPhase  = psel & ~penable;
   wire        accessPhase = psel & penable;
   // writes land on the access edge; the slave never stretches it
   wire        wrStrobe    = accessPhase & pwrite;
   wire        hitEnable   = addrHit(paddr, STATUS_ENABLE_ADDR);
   wire        hitStatus   = addrHit(paddr, STATUS_FLAGS_ADDR);
   wire        hitErrFlags = addrHit(paddr, ERROR_FLAGS_ADDR);
   wire        hitErrEn    = addrHit(paddr, ERROR_ENABLE_ADDR);
   wire        hitAny      = hitEnable | hitStatus | hitErrFlags | hitErrEn;
   wire [7:0]  wrByte      = pwdata[7:0];

   // ==========================================
   // turnaround watchdog, counts idle bit times after an end of packet
   wire        watching    = (watch_reg == WATCH_ARMED);
   wire        idleLimit   = watching & bitTimeTick &
                             (idleCount_reg == TURNAROUND_BIT_TIMES);

   // (RULE8) timeout detect
   // strictly more than 16: the 17th idle bit time fires it
   // a fresh end of packet restarts the count even while armed
   always_comb
   begin
      idleCount_next = idleCount_reg;
      watch_next     = watch_reg;
      case (watch_reg)
         WATCH_IDLE:
         begin
            if (eopSeen)
            begin
               watch_next     = WATCH_ARMED;
               idleCount_next = 5'h00;
            end
         end
         WATCH_ARMED:
         begin
            if (eopSeen)
            begin
               idleCount_next = 5'h00;
            end
            else if (responseSeen | idleLimit)
            begin
               watch_next     = WATCH_IDLE;
               idleCount_next = 5'h00;
            end
            else if (bitTimeTick)
            begin
               idleCount_next = idleCount_reg + 5'h01;
            end
         end
         default:
         begin
            watch_next     = WATCH_IDLE;
            idleCount_next = 5'h00;
         end
      endcase
   end

   // ==========================================
   // error detection vector, same layout as the flags
   wire [7:0]  errorEvent;
   // (RULE13) bit stuffing error
   assign errorEvent[BIT_STUFF_BIT]  = bitStuffError;
   assign errorEvent[6:5]            = 2'h0;
   assign errorEvent[TURNAROUND_BIT] = idleLimit;
   // (RULE9) partial byte data
   assign errorEvent[DATA_SIZE_BIT]  = dataFieldPartial;
   // (RULE10) data crc failure
   assign errorEvent[DATA_CRC_BIT]   = dataCrcFail;
   // (RULE11) token crc failure
   assign errorEvent[TOKEN_CRC_BIT]  = tokenCrcFail;
   // (RULE12) pid check failure
   assign errorEvent[PID_CHECK_BIT]  = pidCheckFail;

   // (RULE5) per-flag enable gating, (RULE17) same positions
   wire [7:0]  maskedErrors = errorFlags_reg & errorEnable_reg & ERROR_MASK;
   // (RULE4) summary OR, (RULE16) only enabled flags count
   wire        summaryNow   = |maskedErrors;

   // summary bit lives in the status flags but is never stored, so
   // software can neither set nor clear it directly
   function automatic logic [7:0] storedStatus
   (
      input logic [7:0] raw
   );
      logic [7:0] summaryMask;
      summaryMask = 8'h01 << ERROR_SUMMARY_BIT;
      return raw & STATUS_MASK & ~summaryMask;
   endfunction

   wire [7:0]  statusView = storedStatus(statusFlags_reg) |
                            ({7'h00, summaryNow} << ERROR_SUMMARY_BIT);

   // (RULE2) enable gating, (RULE3) bit 1 gates summary, (RULE18) OR
   wire        irqNow = |(statusView & statusEnable_reg & STATUS_MASK);

   // ==========================================
   // register next values
   // (RULE14) unimplemented bits masked off on write; status flags also on read
   // (RULE1) seven enable bits
   assign statusEnable_next = (wrStrobe & hitEnable) ?
                              (wrByte & STATUS_MASK) : statusEnable_reg;
   assign errorEnable_next  = (wrStrobe & hitErrEn) ?
                              (wrByte & ERROR_MASK) : errorEnable_reg;

   // (RULE7) write zero clears, (RULE19) write one holds,
   // (RULE6) new detections win over a same-cycle clear
   // (RULE15) set independent of enables
   wire [7:0]  errKeep = (wrStrobe & hitErrFlags) ? wrByte : 8'hFF;
   assign errorFlags_next = ((errorFlags_reg & errKeep) | errorEvent) & ERROR_MASK;

   // status flags: sources set, software may set or clear (debug aid)
   wire [7:0]  statusWr = (wrStrobe & hitStatus) ? wrByte : statusFlags_reg;
   assign statusFlags_next = storedStatus(statusWr | {1'b0, statusEvent});

   // ==========================================
   // read mux
   wire [7:0]  readByte = hitEnable   ? statusEnable_reg :
                          hitStatus   ? statusView :
                          hitErrFlags ? errorFlags_reg :
                          hitErrEn    ? errorEnable_reg : 8'h00;

   // ==========================================
   // flops
   // one block per software register, one shared by the watchdog pair, keeps each reset value beside its flop
   // (RULE20) all clear at reset
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         statusEnable_reg <= STATUS_ENABLE_RESET;
      else
         statusEnable_reg <= statusEnable_next;
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         statusFlags_reg <= STATUS_FLAGS_RESET;
      else
         statusFlags_reg <= statusFlags_next;
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         errorFlags_reg <= ERROR_FLAGS_RESET;
      else
         errorFlags_reg <= errorFlags_next;
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         errorEnable_reg <= ERROR_ENABLE_RESET;
      else
         errorEnable_reg <= errorEnable_next;
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         idleCount_reg <= 5'h00;
         watch_reg     <= WATCH_IDLE;
      end
      else
      begin
         idleCount_reg <= idleCount_next;
         watch_reg     <= watch_next;
      end
   end

   // ==========================================
   // bus answer
   // zero-wait slave: pready comes up in the first access cycle
   // a registered answer costs no wait state, since the setup cycle
   // already carries address and direction
   wire [31:0] readWord    = (setupPhase & ~pwrite) ?
                             {24'h00_0000, readByte} : 32'h0000_0000;
   wire        unmappedNow = setupPhase & ~hitAny;

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= setupPhase;
         prdata  <= readWord;
         pslverr <= unmappedNow;
      end
   end

   // ==========================================
   // engine side outputs
   // (RULE11) token rejected on crc failure
   wire        tokenGood   = tokenValidIn & ~tokenCrcFail;

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         tokenAccepted <= 1'b0;
      else
         tokenAccepted <= tokenGood;
   end

   // (RULE18) interrupt leaves from a flop
   // both levels follow the flag that caused them by one edge
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         moduleInterruptFlag <= 1'b0;
         errorSummaryFlag    <= 1'b0;
      end
      else
      begin
         moduleInterruptFlag <= irqNow;
         errorSummaryFlag    <= summaryNow;
      end
   end
endmodule

// >>> usb_int_props.sv
`timescale 1ns/100ps
module usb_int_props
   import usb_int_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        sys_rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic        pready,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic [6:0]  statusEvent,
   input wire logic        bitTimeTick,
   input wire logic        dataFieldPartial,
   input wire logic        dataCrcFail,
   input wire logic        tokenCrcFail,
   input wire logic        tokenValidIn,
   input wire logic        pidCheckFail,
   input wire logic        bitStuffError,
   input wire logic        tokenAccepted,
   input wire logic        moduleInterruptFlag,
   input wire logic        errorSummaryFlag
);
   // ==========================================
   // helpers
   wire wr = psel & penable & pready & pwrite;
   wire rd = psel & penable & pready & ~pwrite;
   // ticks included: the turnaround flag comes from them
   wire ev = dataFieldPartial | dataCrcFail | tokenCrcFail | pidCheckFail | bitStuffError
      | bitTimeTick;
   wire evWr = ev | wr;
   wire stWr = (|statusEvent) | wr;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // ==========================================
   // properties
   property p_acc; tokenValidIn && !tokenCrcFail |=> tokenAccepted; endproperty
   a_acc: assert property (p_acc) else $error("token dropped");
   property p_rej; tokenCrcFail |=> !tokenAccepted; endproperty
   a_rej: assert property (p_rej) else $error("bad token taken");
   property p_sumUp; $rose(errorSummaryFlag) |-> $past(evWr, 2); endproperty
   a_sumUp: assert property (p_sumUp) else $error("summary rose alone");
   property p_sumDn; $fell(errorSummaryFlag) |-> $past(wr, 2); endproperty
   a_sumDn: assert property (p_sumDn) else $error("summary fell alone");
   property p_mif;
      $rose(moduleInterruptFlag) |-> $past(stWr, 2) || $past(errorSummaryFlag)
         || errorSummaryFlag;
   endproperty
   a_mif: assert property (p_mif) else $error("interrupt rose alone");
   property p_rst;
      disable iff (1'b0) sys_rst |=> !errorSummaryFlag && !moduleInterruptFlag;
   endproperty
   a_rst: assert property (p_rst) else $error("flags after reset");
   property p_rdE; rd && paddr == ERROR_FLAGS_ADDR |-> prdata[6:5] == 2'b00; endproperty
   a_rdE: assert property (p_rdE) else $error("error bits 6:5 set");
   property p_rdS; rd && paddr == STATUS_ENABLE_ADDR |-> !prdata[7]; endproperty
   a_rdS: assert property (p_rdS) else $error("enable bit 7 set");
   cover property ($rose(errorSummaryFlag));
   cover property ($rose(moduleInterruptFlag));
   cover property (tokenValidIn && tokenCrcFail);
endmodule
bind usb_int_enable_error_status usb_int_props usb_int_props_i (.clk_sys, .sys_rst, .psel,
   .penable, .pwrite, .pready, .paddr, .prdata, .statusEvent, .bitTimeTick, .dataFieldPartial,
   .dataCrcFail, .tokenCrcFail, .tokenValidIn, .pidCheckFail, .bitStuffError, .tokenAccepted,
   .moduleInterruptFlag, .errorSummaryFlag);

// >>> usb_int_enable_error_status_test.sv
`timescale 1ns/100ps
`define CHK(a,b) begin checkCount++; if ((a) !== (b)) begin errors++; \
   $display("ERROR %0t got %h", $time, a); end end
module usb_int_enable_error_status_test;
   import usb_int_pkg::*;
   logic        clk_sys = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        tokenValidIn = 1'b0, slv;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd, v = 32'hA8B3C2F0;
   logic [7:0]  sb = 8'h00;
   logic [6:0]  statusEvent = 7'h00;
   wire         pready, pslverr, moduleInterruptFlag, errorSummaryFlag, tokenAccepted;
   wire  [31:0] prdata;
   int          errors, checkCount;
   usb_int_enable_error_status usb_int_enable_error_status_i (.clk_sys, .sys_rst, .psel,
      .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .statusEvent,
      .bitTimeTick(sb[6]), .eopSeen(sb[5]), .responseSeen(sb[7]), .dataFieldPartial(sb[3]),
      .dataCrcFail(sb[2]), .tokenCrcFail(sb[1]), .tokenValidIn, .pidCheckFail(sb[0]),
      .bitStuffError(sb[4]), .tokenAccepted, .moduleInterruptFlag, .errorSummaryFlag);
   // ==========================================
   // helpers
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // stuffing error lands in bit 7, the rest in place
   function automatic logic [7:0] eb(input int i);
      return (i < 4) ? 8'h01 << i : 8'h80;
   endfunction
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic pls(input logic [7:0] m, input int n);
      repeat (n)
      begin
         @(posedge clk_sys);
         sb <= m;
         @(posedge clk_sys);
         sb <= 8'h00;
      end
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", checkCount, errors);
      if (errors == 0 && checkCount > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // ==========================================
   // stimulus
   initial forever #50 clk_sys = ~clk_sys;
   initial
   begin
      #1000000;
      errors++;
      end_sim;
   end
   initial
   begin
      repeat (3) @(posedge clk_sys);
      sys_rst <= 1'b0;
      for (int k = 0; k < 4; k++)
      begin
         apb(0, 12'(4 * k), 0);
         `CHK(rd, 32'h0)
      end
      apb(1, STATUS_ENABLE_ADDR, 8'hFF);
      apb(0, STATUS_ENABLE_ADDR, 0);
      `CHK(rd, 32'h7F)
      apb(1, ERROR_ENABLE_ADDR, 8'hFF);
      apb(0, ERROR_ENABLE_ADDR, 0);
      `CHK(rd, 32'h9F)
      apb(0, 12'h010, 0);
      `CHK(slv, 1'b1)
      `CHK(rd, 32'h0)
      apb(1, STATUS_ENABLE_ADDR, 8'h02);
      for (int i = 0; i < 5; i++)
      begin
         apb(1, ERROR_ENABLE_ADDR, 0);
         pls(8'h01 << i, 1);
         apb(0, ERROR_FLAGS_ADDR, 0);
         `CHK(rd[7:0], eb(i))
         `CHK(errorSummaryFlag, 1'b0)
         apb(1, ERROR_ENABLE_ADDR, eb(i));
         repeat (3) @(posedge clk_sys);
         `CHK(errorSummaryFlag, 1'b1)
         `CHK(moduleInterruptFlag, 1'b1)
         apb(1, ERROR_FLAGS_ADDR, 8'hFF);
         apb(0, ERROR_FLAGS_ADDR, 0);
         `CHK(rd[7:0], eb(i))
         apb(1, ERROR_FLAGS_ADDR, 0);
         apb(0, ERROR_FLAGS_ADDR, 0);
         `CHK(rd[7:0], 8'h00)
         `CHK(errorSummaryFlag, 1'b0)
      end
      pls(8'h20, 1);
      pls(8'h40, 16);
      apb(0, ERROR_FLAGS_ADDR, 0);
      `CHK(rd[4], 1'b0)
      pls(8'h40, 1);
      apb(0, ERROR_FLAGS_ADDR, 0);
      `CHK(rd[4], 1'b1)
      apb(1, ERROR_FLAGS_ADDR, 0);
      pls(8'h20, 1);
      pls(8'h40, 5);
      pls(8'h80, 1);
      pls(8'h40, 20);
      apb(0, ERROR_FLAGS_ADDR, 0);
      `CHK(rd[4], 1'b0)
      repeat (20)
      begin
         v = lfsr(v);
         apb(1, STATUS_FLAGS_ADDR, 0);
         apb(1, STATUS_ENABLE_ADDR, v[7:0]);
         statusEvent <= v[14:8];
         tokenValidIn <= v[16];
         sb <= {6'h00, v[17], 1'b0};
         @(posedge clk_sys);
         statusEvent <= 7'h00;
         tokenValidIn <= 1'b0;
         sb <= 8'h00;
         @(negedge clk_sys);
         `CHK(tokenAccepted, v[16] & ~v[17])
         repeat (3) @(posedge clk_sys);
         `CHK(moduleInterruptFlag, |(v[6:0] & v[14:8] & 7'h7D))
         apb(0, STATUS_FLAGS_ADDR, 0);
         `CHK(rd[7:0], {1'b0, v[14:8] & 7'h7D})
      end
      end_sim;
   end
endmodule
